// ### verilog/cfg_access_pkg.sv
// Constants shared by the configuration access block and its tests.
package cfg_access_pkg;
    // Clock and side-effect delay.
    localparam int CLOCK_KHZ = 20000;
    localparam int SIDE_EFFECT_DELAY_US = 1000;
    localparam int SIDE_EFFECT_DELAY_CYCLES = (SIDE_EFFECT_DELAY_US * CLOCK_KHZ) / 1000;
    localparam int TIMER_WIDTH = 24;

    // Global address space: 19-bit byte address, 17-bit DWord address.
    localparam int GLOBAL_ADDR_WIDTH = 19;
    localparam int GLOBAL_DW_WIDTH = 17;
    localparam logic [16:0] BRIDGE_REGION_DW_END = 17'h0_0400;
    localparam logic [16:0] SWITCH_PORT_CONTROL_DW = 17'h0_F840;

    // Function-local DWord offsets (register offset bits 11:2).
    localparam logic [9:0] PHY_LINK_STATE_DW = 10'h140;
    localparam logic [9:0] GLOBAL_ACCESS_ADDRESS_DW = 10'h3FE;
    localparam logic [9:0] GLOBAL_ACCESS_DATA_DW = 10'h3FF;

    // Field positions and reset values.
    localparam int FULL_LINK_RETRAIN_BIT = 0;
    localparam int PORT_MODE_LSB = 0;
    localparam logic [1:0] MODE_DOWNSTREAM = 2'h0;
    localparam logic [1:0] MODE_UPSTREAM = 2'h1;
    localparam logic [1:0] MODE_DISABLED = 2'h2;
    localparam logic [1:0] PORT_MODE_RESET = MODE_UPSTREAM;
    localparam logic [16:0] GLOBAL_ACCESS_ADDRESS_RESET = 17'h0_0000;

    // Completion status codes.
    localparam logic [2:0] CPL_SUCCESS = 3'h0;
    localparam logic [2:0] CPL_UNSUPPORTED = 3'h1;

    typedef enum logic [2:0] {
        TGT_MEM = 3'b000,
        TGT_PHY = 3'b001,
        TGT_SWCTL = 3'b010,
        TGT_GAA = 3'b011,
        TGT_RSVD = 3'b100
    } target_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_CPL = 2'b10
    } state_t;
endpackage : cfg_access_pkg

// ### verilog/cfg_word_store.sv
// Byte-writable word store with registered read data.
module cfg_word_store #(
    parameter int DEPTH = 256,
    parameter int ADDR_WIDTH = 8
) (
    // Clock.
    input wire logic i_clock,
    // Write port.
    input wire logic i_wr_en,
    input wire logic [ADDR_WIDTH-1:0] i_wr_addr,
    input wire logic [3:0] i_wr_be,
    input wire logic [31:0] i_wr_data,
    // Read port.
    input wire logic [ADDR_WIDTH-1:0] i_rd_addr,
    output logic [31:0] o_rd_data
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (i_wr_be[b]) begin
                    mem[i_wr_addr][8*b +: 8] <= i_wr_data[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        o_rd_data <= mem[i_rd_addr];
    end
endmodule : cfg_word_store

// ### verilog/config_register_access_control.sv
// Configuration request handling with delayed side effects and indirect global access.
// Operation
// - Completion goes out before any side effect.
// - Side effect waits 1 ms after completion.
// - Unaccepted completion is dropped when delay expires.
// - Delay applies to retrain bit and port mode.
// - Reserved reads return undefined data, here zero.
// - Reserved writes still complete successfully.
// - Bridge answers as function 0 in switch modes.
// - One 19-bit global space, bridge and switch regions.
// - Indirect address/data pair reaches any global register except the address/data pair itself.
module config_register_access_control #(
    parameter int DELAY_CYCLES = cfg_access_pkg::SIDE_EFFECT_DELAY_CYCLES,
    parameter int STORE_DEPTH = 256,
    parameter int STORE_AW = 8
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Configuration request.
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_write,
    input wire logic [2:0] i_req_func,
    input wire logic [9:0] i_req_addr,
    input wire logic [3:0] i_req_be,
    input wire logic [31:0] i_req_wdata,
    // Completion.
    output logic o_cpl_valid,
    input wire logic i_cpl_ready,
    output logic [2:0] o_cpl_status,
    output logic [31:0] o_cpl_rdata,
    // Side-effect actions.
    output logic [1:0] o_port_mode,
    output logic o_link_retrain
);
    cfg_access_pkg::state_t state;
    cfg_access_pkg::target_t target;
    logic [16:0] global_access_address;
    logic [1:0] port_mode;
    logic [1:0] pending_mode;
    logic pending_retrain;
    logic pending_mode_set;
    logic [cfg_access_pkg::TIMER_WIDTH-1:0] timer;
    logic timer_run;
    logic arm_timer;
    logic expire;
    logic [STORE_AW-1:0] store_addr;
    logic [31:0] store_rdata;
    logic [31:0] local_rdata;
    logic [2:0] status;
    logic write_side_effect;
    logic req_is_write;

    localparam int DELAY_LAST_INT = DELAY_CYCLES - 1;
    localparam logic [cfg_access_pkg::TIMER_WIDTH-1:0] DELAY_LAST =
        DELAY_LAST_INT[cfg_access_pkg::TIMER_WIDTH-1:0];

    // Resolves a function-local DWord offset; indirect lookups cannot nest.
    function automatic cfg_access_pkg::target_t local_target(input logic [9:0] dw, input logic indirect);
        if (dw == cfg_access_pkg::PHY_LINK_STATE_DW) begin
            return cfg_access_pkg::TGT_PHY;
        end
        if (dw == cfg_access_pkg::GLOBAL_ACCESS_ADDRESS_DW && !indirect) begin
            return cfg_access_pkg::TGT_GAA;
        end
        if (dw < 10'(STORE_DEPTH)) begin
            return cfg_access_pkg::TGT_MEM;
        end
        return cfg_access_pkg::TGT_RSVD;
    endfunction : local_target

    // Maps a global DWord address onto this block's registers.
    function automatic cfg_access_pkg::target_t global_target(input logic [16:0] gdw);
        if (gdw < cfg_access_pkg::BRIDGE_REGION_DW_END) begin
            return local_target(gdw[9:0], 1'b1);
        end
        if (gdw == cfg_access_pkg::SWITCH_PORT_CONTROL_DW) begin
            return cfg_access_pkg::TGT_SWCTL;
        end
        return cfg_access_pkg::TGT_RSVD;
    endfunction : global_target

    logic accept;
    logic func_ok;
    logic is_gad;
    cfg_access_pkg::target_t req_target;
    logic [9:0] req_local_dw;

    assign o_req_ready = (state == cfg_access_pkg::ST_IDLE);
    assign accept = i_req_valid && o_req_ready;
    // Only function 0 exists, and only while the port runs as a switch port.
    assign func_ok = (i_req_func == 3'h0) &&
        (port_mode == cfg_access_pkg::MODE_UPSTREAM || port_mode == cfg_access_pkg::MODE_DOWNSTREAM);
    assign is_gad = (i_req_addr == cfg_access_pkg::GLOBAL_ACCESS_DATA_DW);
    assign req_target = is_gad ? global_target(global_access_address) : local_target(i_req_addr, 1'b0);
    assign req_local_dw = is_gad ? global_access_address[9:0] : i_req_addr;
    assign store_addr = req_local_dw[STORE_AW-1:0];
    assign write_side_effect = accept && func_ok && i_req_write &&
        ((req_target == cfg_access_pkg::TGT_PHY && i_req_be[0]) ||
         (req_target == cfg_access_pkg::TGT_SWCTL && i_req_be[0]));
    // A restart in the expiry cycle wins, so a freshly recorded action never fires before its own wait.
    assign expire = timer_run && (timer == DELAY_LAST) && !arm_timer;

    // Byte enables are honoured as given; odd widths simply merge the enabled lanes.
    cfg_word_store #(
        .DEPTH(STORE_DEPTH),
        .ADDR_WIDTH(STORE_AW)
    ) u_store (
        .i_clock(i_clock),
        .i_wr_en(accept && func_ok && i_req_write && req_target == cfg_access_pkg::TGT_MEM),
        .i_wr_addr(store_addr),
        .i_wr_be(i_req_be),
        .i_wr_data(i_req_wdata),
        .i_rd_addr(store_addr),
        .o_rd_data(store_rdata)
    );

    // Request sequencing: accept, one cycle for read data, then hold completion.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state <= cfg_access_pkg::ST_IDLE;
            target <= cfg_access_pkg::TGT_RSVD;
            status <= cfg_access_pkg::CPL_SUCCESS;
            arm_timer <= 1'b0;
            req_is_write <= 1'b0;
        end else begin
            arm_timer <= 1'b0;
            case (state)
                cfg_access_pkg::ST_IDLE: begin
                    if (accept) begin
                        target <= req_target;
                        status <= func_ok ? cfg_access_pkg::CPL_SUCCESS : cfg_access_pkg::CPL_UNSUPPORTED;
                        state <= cfg_access_pkg::ST_READ;
                        req_is_write <= i_req_write;
                        arm_timer <= write_side_effect;
                    end
                end
                cfg_access_pkg::ST_READ: begin
                    state <= cfg_access_pkg::ST_CPL;
                end
                cfg_access_pkg::ST_CPL: begin
                    // A completion still waiting when the action fires is lost.
                    if (i_cpl_ready || expire) begin
                        state <= cfg_access_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= cfg_access_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (target)
            cfg_access_pkg::TGT_PHY: local_rdata = {31'h0, pending_retrain};
            cfg_access_pkg::TGT_SWCTL: local_rdata = {30'h0, port_mode};
            cfg_access_pkg::TGT_GAA: local_rdata = {13'h0, global_access_address, 2'h0};
            default: local_rdata = 32'h0000_0000;
        endcase
    end

    // Completion data is captured once the store has answered.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_cpl_rdata <= 32'h0000_0000;
        end else if (state == cfg_access_pkg::ST_READ) begin
            // Write completions carry no data, so a stale or unwritten store word never leaks out.
            if (status != cfg_access_pkg::CPL_SUCCESS || req_is_write) begin
                o_cpl_rdata <= 32'h0000_0000;
            end else if (target == cfg_access_pkg::TGT_MEM) begin
                o_cpl_rdata <= store_rdata;
            end else begin
                o_cpl_rdata <= local_rdata;
            end
        end
    end

    assign o_cpl_valid = (state == cfg_access_pkg::ST_CPL);
    assign o_cpl_status = status;

    // Indirect address register.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            global_access_address <= cfg_access_pkg::GLOBAL_ACCESS_ADDRESS_RESET;
        end else if (accept && func_ok && i_req_write && req_target == cfg_access_pkg::TGT_GAA) begin
            global_access_address <= i_req_wdata[cfg_access_pkg::GLOBAL_ADDR_WIDTH-1:2];
        end
    end

    // The timer is armed one cycle after acceptance, the cycle the completion is raised.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            timer <= '0;
            timer_run <= 1'b0;
        end else if (arm_timer) begin
            timer <= '0;
            timer_run <= 1'b1;
        end else if (expire) begin
            timer_run <= 1'b0;
        end else if (timer_run) begin
            timer <= timer + 1'b1;
        end
    end

    // Pending records; a fresh write restarts the shared wait so each action still trails its completion.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pending_retrain <= 1'b0;
            pending_mode_set <= 1'b0;
            pending_mode <= cfg_access_pkg::PORT_MODE_RESET;
        end else begin
            if (expire) begin
                pending_retrain <= 1'b0;
                pending_mode_set <= 1'b0;
            end
            if (write_side_effect && req_target == cfg_access_pkg::TGT_PHY &&
                i_req_wdata[cfg_access_pkg::FULL_LINK_RETRAIN_BIT]) begin
                pending_retrain <= 1'b1;
            end
            if (write_side_effect && req_target == cfg_access_pkg::TGT_SWCTL) begin
                pending_mode_set <= 1'b1;
                pending_mode <= i_req_wdata[cfg_access_pkg::PORT_MODE_LSB +: 2];
            end
        end
    end

    // Actions fire only on expiry, never before the completion went out.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            port_mode <= cfg_access_pkg::PORT_MODE_RESET;
            o_link_retrain <= 1'b0;
        end else begin
            o_link_retrain <= expire && pending_retrain;
            if (expire && pending_mode_set) begin
                port_mode <= pending_mode;
            end
        end
    end

    assign o_port_mode = port_mode;
endmodule : config_register_access_control

// ### sim/config_register_access_control_checker.sv
// Port-level assertions for the configuration access block.
module config_register_access_control_checker #(
    parameter int DELAY_CYCLES = 20
) (
    // Clock, reset and request.
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire logic i_req_write,
    input wire logic [2:0] i_req_func,
    input wire logic [9:0] i_req_addr,
    input wire logic [3:0] i_req_be,
    input wire logic [31:0] i_req_wdata,
    // Completion and side effects.
    input wire logic o_cpl_valid,
    input wire logic i_cpl_ready,
    input wire logic [2:0] o_cpl_status,
    input wire logic [31:0] o_cpl_rdata,
    input wire logic [1:0] o_port_mode,
    input wire logic o_link_retrain
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LO = DELAY_CYCLES;
    localparam int HI = DELAY_CYCLES + 3;
    localparam int EARLY = DELAY_CYCLES - 2;
    logic taken;
    logic retrain_wr;
    logic [23:0] since_cpl;
    assign taken = i_req_valid && o_req_ready;
    // Unsupported requests never arm an action, so a disabled port is left out.
    assign retrain_wr = taken && i_req_write && i_req_func == 3'h0 && i_req_be[0]
        && i_req_wdata[cfg_access_pkg::FULL_LINK_RETRAIN_BIT] && o_port_mode != cfg_access_pkg::MODE_DISABLED
        && i_req_addr == cfg_access_pkg::PHY_LINK_STATE_DW;
    // Saturates so that a long idle spell never wraps into a false early count.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || $rose(o_cpl_valid)) since_cpl <= 24'h00_0000;
        else if (since_cpl != 24'hFF_FFFF) since_cpl <= since_cpl + 24'h00_0001;
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    cpl_latency_a: assert property (taken |=> !o_cpl_valid ##1 o_cpl_valid)
        else $error("completion latency wrong");
    cpl_release_a: assert property (o_cpl_valid && i_cpl_ready |=> !o_cpl_valid && o_req_ready)
        else $error("completion not released");
    cpl_hold_a: assert property (o_cpl_valid && !i_cpl_ready |=>
        o_cpl_valid && $stable(o_cpl_rdata) && $stable(o_cpl_status) || o_link_retrain || $changed(o_port_mode))
        else $error("completion changed while waiting");
    retrain_delay_a: assert property (retrain_wr |-> ##[LO:HI] o_link_retrain)
        else $error("retrain not executed after delay");
    effect_early_a: assert property (o_link_retrain || $changed(o_port_mode) |-> since_cpl >= EARLY)
        else $error("side effect before delay ran out");
    retrain_once_a: assert property (o_link_retrain |=> !o_link_retrain)
        else $error("retrain executed twice");
    other_func_a: assert property (taken && i_req_func != 3'h0 |=> ##1
        o_cpl_status == cfg_access_pkg::CPL_UNSUPPORTED && o_cpl_rdata == 32'h0000_0000)
        else $error("nonzero function answered");
    func_zero_a: assert property (taken && i_req_func == 3'h0 |=> ##1 o_cpl_status ==
        ($past(o_port_mode, 2) == cfg_access_pkg::MODE_DISABLED ? cfg_access_pkg::CPL_UNSUPPORTED
        : cfg_access_pkg::CPL_SUCCESS)) else $error("function zero status wrong");
    cover property (o_link_retrain);
    cover property ($changed(o_port_mode));
    cover property ($fell(o_cpl_valid) && !$past(i_cpl_ready));
endmodule : config_register_access_control_checker

// ### sim/cfg_requester_model.sv
// Requester model that issues one configuration request at a time.
module cfg_requester_model (
    // Command from the bench.
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic i_write,
    input wire logic [2:0] i_func,
    input wire logic [9:0] i_addr,
    input wire logic [3:0] i_be,
    input wire logic [31:0] i_wdata,
    input wire logic [7:0] i_stall,
    output logic o_busy,
    // Request and completion towards the block.
    output logic o_req_valid,
    input wire logic i_req_ready,
    output logic o_req_write,
    output logic [2:0] o_req_func,
    output logic [9:0] o_req_addr,
    output logic [3:0] o_req_be,
    output logic [31:0] o_req_wdata,
    output logic o_cpl_ready,
    input wire logic i_cpl_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    int n;
    initial begin
        {o_busy, o_req_valid, o_req_write, o_cpl_ready, o_req_func} = 7'h00;
        {o_req_addr, o_req_be, o_req_wdata} = 46'h0;
        forever begin
            @(posedge i_clock);
            if (i_go) begin
                #1;
                o_busy = 1'b1;
                // Byte enables are native size or a full DWord; the port is never crosslinked.
                {o_req_valid, o_req_write, o_req_func, o_req_addr} = {1'b1, i_write, i_func, i_addr};
                {o_req_be, o_req_wdata} = {i_be, i_wdata};
                @(posedge i_clock iff i_req_ready);
                #1;
                o_req_valid = 1'b0;
                // Released lines toggle so a stale value is never mistaken for a live one.
                {o_req_addr, o_req_be, o_req_wdata} = ~{o_req_addr, o_req_be, o_req_wdata};
                // Completions are taken promptly unless a stall is asked for.
                repeat (i_stall) @(posedge i_clock);
                #1;
                o_cpl_ready = 1'b1;
                n = 0;
                @(posedge i_clock);
                while (!i_cpl_valid && n < 8) begin
                    n++;
                    @(posedge i_clock);
                end
                #1;
                {o_cpl_ready, o_busy} = 2'b00;
            end
        end
    end
endmodule : cfg_requester_model

// ### sim/config_register_access_control_bench.sv
// Self-checking bench for the configuration access block.
module config_register_access_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DLY = 20;
    localparam logic [2:0] OKS = cfg_access_pkg::CPL_SUCCESS;
    localparam logic [35:0] OK0 = {1'b1, OKS, 32'h0000_0000};
    localparam logic [35:0] UNS = {1'b1, cfg_access_pkg::CPL_UNSUPPORTED, 32'h0000_0000};
    localparam logic [35:0] NONE = {1'b0, 3'h7, 32'h0000_0000};
    logic clock, rst_n, go, write, busy, req_valid, req_ready, req_write, cpl_valid, cpl_ready, link_retrain;
    logic [2:0] func, req_func, cpl_status;
    logic [9:0] addr, req_addr;
    logic [3:0] be, req_be;
    logic [31:0] wdata, req_wdata, cpl_rdata;
    logic [7:0] stall;
    logic [1:0] port_mode, last_mode;
    logic [35:0] exp_cpl [$];
    logic [2:0] exp_fx [$];
    int fail_count = 0;
    int checked = 0;
    config_register_access_control #(.DELAY_CYCLES(DLY)) i_dut (.i_clock(clock), .i_rst_n(rst_n),
        .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_write(req_write), .i_req_func(req_func),
        .i_req_addr(req_addr), .i_req_be(req_be), .i_req_wdata(req_wdata), .o_cpl_valid(cpl_valid),
        .i_cpl_ready(cpl_ready), .o_cpl_status(cpl_status), .o_cpl_rdata(cpl_rdata), .o_port_mode(port_mode),
        .o_link_retrain(link_retrain));
    cfg_requester_model i_req (.i_clock(clock), .i_go(go), .i_write(write), .i_func(func), .i_addr(addr),
        .i_be(be), .i_wdata(wdata), .i_stall(stall), .o_busy(busy), .o_req_valid(req_valid),
        .i_req_ready(req_ready), .o_req_write(req_write), .o_req_func(req_func), .o_req_addr(req_addr),
        .o_req_be(req_be), .o_req_wdata(req_wdata), .o_cpl_ready(cpl_ready), .i_cpl_valid(cpl_valid));
    task automatic conclude();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Bit 35 of a note says whether read data is compared as well as status.
    task automatic compare_cpl(input logic [35:0] e);
        checked++;
        if (e[35] ? {cpl_status, cpl_rdata} !== e[34:0] : cpl_status !== e[34:32]) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e[34:0], {cpl_status, cpl_rdata});
        end
    endtask : compare_cpl
    task automatic compare_fx(input logic [2:0] e, input logic [2:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : compare_fx
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic req(input logic w, input logic [9:0] a, input logic [3:0] b, input logic [31:0] d,
        input logic [35:0] e, input logic [2:0] f = 3'h0, input logic [7:0] s = 8'h00);
        if (e[34:32] != 3'h7) exp_cpl.push_back(e);
        {write, func, addr, be, wdata, stall, go} = {w, f, a, b, d, s, 1'b1};
        idle(1);
        go = 1'b0;
        repeat (2) @(posedge clock);
        while (busy) @(posedge clock);
        #1;
    endtask : req
    always @(posedge clock) begin
        if (rst_n && cpl_valid && cpl_ready) compare_cpl(exp_cpl.size() > 0 ? exp_cpl.pop_front() : NONE);
        if (rst_n && link_retrain) compare_fx(exp_fx.size() > 0 ? exp_fx.pop_front() : 3'h0, 3'h4);
        if (rst_n && port_mode !== last_mode) compare_fx(exp_fx.size() > 0 ? exp_fx.pop_front() : 3'h7,
            {1'b0, port_mode});
        last_mode = port_mode;
    end
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        conclude();
    end
    initial begin
        logic [31:0] mem [8];
        logic [9:0] ad [8];
        logic [1:0] modes [3];
        int i;
        {rst_n, go, write, func, addr, be, wdata, stall} = 60'h0;
        modes = '{cfg_access_pkg::MODE_DOWNSTREAM, cfg_access_pkg::MODE_UPSTREAM, cfg_access_pkg::MODE_DISABLED};
        i = $urandom(77);
        idle(16);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            ad[i] = 10'(i * 32 + $urandom_range(31));
            mem[i] = $urandom;
            req(1'b1, ad[i], 4'hF, mem[i], OK0);
        end
        wdata = $urandom;
        mem[0][7:0] = wdata[7:0];
        req(1'b1, ad[0], 4'h1, wdata, OK0);
        for (i = 0; i < 8; i++) req(1'b0, ad[i], 4'hF, 32'h0000_0000, {1'b1, OKS, mem[i]});
        req(1'b1, 10'h200, 4'hF, $urandom, OK0);
        req(1'b0, 10'h200, 4'hF, 32'h0000_0000, {1'b0, OKS, 32'h0000_0000});
        for (i = 1; i < 8; i++) req(1'b0, ad[1], 4'hF, 32'h0000_0000, UNS, 3'(i));
        req(1'b1, cfg_access_pkg::GLOBAL_ACCESS_ADDRESS_DW, 4'hF, 32'(ad[2]) << 2, OK0);
        req(1'b0, cfg_access_pkg::GLOBAL_ACCESS_ADDRESS_DW, 4'hF, 32'h0, {1'b1, OKS, 32'(ad[2]) << 2});
        req(1'b0, cfg_access_pkg::GLOBAL_ACCESS_DATA_DW, 4'hF, 32'h0, {1'b1, OKS, mem[2]});
        mem[2] = $urandom;
        req(1'b1, cfg_access_pkg::GLOBAL_ACCESS_DATA_DW, 4'hF, mem[2], OK0);
        req(1'b0, ad[2], 4'hF, 32'h0, {1'b1, OKS, mem[2]});
        exp_fx.push_back(3'h4);
        req(1'b1, cfg_access_pkg::PHY_LINK_STATE_DW, 4'h1, 32'h0000_0001, OK0);
        idle(DLY + 6);
        // The stall outlasts the delay, so this completion must be lost.
        exp_fx.push_back(3'h4);
        req(1'b1, cfg_access_pkg::PHY_LINK_STATE_DW, 4'h1, 32'h0000_0001, NONE, 3'h0, 8'(DLY + 5));
        req(1'b1, cfg_access_pkg::GLOBAL_ACCESS_ADDRESS_DW, 4'hF,
            32'(cfg_access_pkg::SWITCH_PORT_CONTROL_DW) << 2, OK0);
        for (i = 0; i < 3; i++) begin
            exp_fx.push_back({1'b0, modes[i]});
            req(1'b1, cfg_access_pkg::GLOBAL_ACCESS_DATA_DW, 4'hF, 32'(modes[i]) << cfg_access_pkg::PORT_MODE_LSB,
                OK0);
            idle(DLY + 6);
        end
        req(1'b0, ad[3], 4'hF, 32'h0, UNS);
        compare_fx(3'(exp_fx.size() + exp_cpl.size()), 3'h0);
        conclude();
    end
endmodule : config_register_access_control_bench
bind config_register_access_control config_register_access_control_checker #(.DELAY_CYCLES(DELAY_CYCLES)) i_chk (
    .i_clock, .i_rst_n, .i_req_valid, .o_req_ready, .i_req_write, .i_req_func, .i_req_addr, .i_req_be,
    .i_req_wdata, .o_cpl_valid, .i_cpl_ready, .o_cpl_status, .o_cpl_rdata, .o_port_mode, .o_link_retrain);
